// ### design/sep_pkg.sv
// shared constants for the storage element pair
package sep_pkg;

	// system clock period in picoseconds (200 MHz)
	localparam int CLOCK_PERIOD_PS = 5000;

	// least time the surviving direct input must stay true after a double
	// assertion before the flip-flop takes its state
	localparam int DC_HOLD_NS = 40;

	// least time rounds up to whole cycles, never below one
	localparam int DC_HOLD_CYCLES_RAW =
		(DC_HOLD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int DC_HOLD_CYCLES =
		(DC_HOLD_CYCLES_RAW < 1) ? 1 : DC_HOLD_CYCLES_RAW;

	// width of the release hold counter
	localparam int DC_CNT_W = 4;

	// reset values of the storage state
	localparam logic RST_STATE = 1'h0;
	localparam logic RST_LATCH = 1'h0;
	localparam logic RST_RANK = 1'h0;

endpackage

// ### design/sep_storage_pair.sv
// two-rank clocked flip-flop with direct preset/clear, and set-override latch

// Operation
// - while the element clock is high, flip-flop outputs keep their state
// - on the element clock falling edge, first rank moves into outputs
// - while the element clock is low, the first rank holds its capture
// - with wipe true, latch output follows the high input
// - with wipe false, output sets on high and stays set
// - high and wipe both true: set wins, output follows high
// - set and reset both true at the edge: flip-flop ends up set
// - set and reset both false at the edge: outputs stay unchanged
// - direct preset and clear override the whole clocked path
// - both direct inputs true drive both outputs false; survivor decides
module sep_storage_pair
(
	// system clock and synchronous reset
	input wire logic clock,
	input wire logic srst,

	// flip-flop clocked inputs
	input wire logic phaseClk,
	input wire logic setIn,
	input wire logic resetIn,

	// flip-flop direct inputs
	input wire logic presetIn,
	input wire logic clearIn,

	// flip-flop outputs
	output logic stateOut,
	output logic stateOutN,

	// latch inputs
	input wire logic highIn,
	input wire logic wipeIn,

	// latch output
	output logic outBit
);

	localparam logic [sep_pkg::DC_CNT_W-1:0] HOLD_LAST =
		sep_pkg::DC_CNT_W'(sep_pkg::DC_HOLD_CYCLES - 1);

	logic phasePrev_r;
	logic setRank_r;
	logic rstRank_r;
	logic q_r;
	logic qn_r;
	logic dcBoth_r;
	logic [sep_pkg::DC_CNT_W-1:0] holdCnt_r;
	logic latch_r;
	logic fallEdge;
	logic dcAny;

	// falling edge of the element clock as seen on the system clock
	assign fallEdge = phasePrev_r & ~phaseClk;
	assign dcAny = presetIn | clearIn;

	// previous element clock level for edge detection
	always_ff @(posedge clock)
	begin
		if (srst)
			phasePrev_r <= 1'h0;
		else
			phasePrev_r <= phaseClk;
	end

	// first rank primes only while the element clock is high
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			setRank_r <= sep_pkg::RST_RANK;
			rstRank_r <= sep_pkg::RST_RANK;
		end
		else if (phaseClk)
		begin
			setRank_r <= setIn;
			rstRank_r <= resetIn;
		end
	end

	// second rank: direct inputs first, then the falling-edge transfer
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			q_r <= sep_pkg::RST_STATE;
			qn_r <= ~sep_pkg::RST_STATE;
			dcBoth_r <= 1'h0;
			holdCnt_r <= '0;
		end
		else if (presetIn && clearIn)
		begin
			q_r <= 1'h0;
			qn_r <= 1'h0;
			dcBoth_r <= 1'h1;
			holdCnt_r <= '0;
		end
		else if (dcAny)
		begin
			// survivor must stay true for the hold time after a double
			if (dcBoth_r && holdCnt_r < HOLD_LAST)
				holdCnt_r <= holdCnt_r + 1'h1;
			else
			begin
				q_r <= presetIn;
				qn_r <= ~presetIn;
				dcBoth_r <= 1'h0;
				holdCnt_r <= '0;
			end
		end
		// simultaneous release is indeterminate; settle to cleared
		else if (dcBoth_r)
		begin
			q_r <= 1'h0;
			qn_r <= 1'h1;
			dcBoth_r <= 1'h0;
			holdCnt_r <= '0;
		end
		else if (fallEdge)
		begin
			if (setRank_r)
			begin
				q_r <= 1'h1;
				qn_r <= 1'h0;
			end
			else if (rstRank_r)
			begin
				q_r <= 1'h0;
				qn_r <= 1'h1;
			end
		end
	end

	// latch: wipe true follows high, wipe false makes it sticky
	always_ff @(posedge clock)
	begin
		if (srst)
			latch_r <= sep_pkg::RST_LATCH;
		else if (highIn)
			latch_r <= 1'h1;
		else if (wipeIn)
			latch_r <= 1'h0;
	end

	// outputs straight from the storage flops
	assign stateOut = q_r;
	assign stateOutN = qn_r;
	assign outBit = latch_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_bothDc;
		presetIn && clearIn;
	endsequence

	sequence s_presetOnly;
		presetIn && !clearIn;
	endsequence

	// outputs never move while clock is high and nothing direct acts
	property p_highHold;
		phaseClk && !dcAny && !dcBoth_r |=> $stable(q_r) && $stable(qn_r);
	endproperty
	a_highHold: assert property (p_highHold)
		else $error("flip-flop output moved while element clock high");

	// a captured set appears exactly one cycle after the fall is seen
	property p_fallSet;
		fallEdge && !dcAny && !dcBoth_r && setRank_r |=> q_r && !qn_r;
	endproperty
	a_fallSet: assert property (p_fallSet)
		else $error("captured set not transferred at falling edge");

	// no change away from a fall without direct inputs
	property p_onlyAtFall;
		!fallEdge && !dcAny && !dcBoth_r |=> $stable(q_r);
	endproperty
	a_onlyAtFall: assert property (p_onlyAtFall)
		else $error("flip-flop output changed away from falling edge");

	// first rank ignores its inputs while clock is low
	property p_lowRank;
		!phaseClk |=> $stable(setRank_r) && $stable(rstRank_r);
	endproperty
	a_lowRank: assert property (p_lowRank)
		else $error("first rank changed while element clock low");

	// wipe true: output copies the high input one cycle later
	property p_follow;
		wipeIn |=> outBit == $past(highIn);
	endproperty
	a_follow: assert property (p_follow)
		else $error("latch did not follow high input in wipe mode");

	// wipe false: once set it stays set
	property p_sticky;
		!wipeIn && outBit |=> outBit;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("latch dropped while wipe false");

	// set and wipe together: set wins
	property p_setWins;
		highIn && wipeIn |=> outBit;
	endproperty
	a_setWins: assert property (p_setWins)
		else $error("latch not set when high and wipe both true");

	// set and reset both captured: flip-flop ends set
	property p_bothClocked;
		fallEdge && !dcAny && !dcBoth_r && setRank_r && rstRank_r
			|=> q_r && !qn_r;
	endproperty
	a_bothClocked: assert property (p_bothClocked)
		else $error("set did not override reset at falling edge");

	// neither captured: state kept across the fall
	property p_neither;
		fallEdge && !dcAny && !dcBoth_r && !setRank_r && !rstRank_r
			|=> $stable(q_r) && $stable(qn_r);
	endproperty
	a_neither: assert property (p_neither)
		else $error("flip-flop changed with set and reset both false");

	// single direct clear forces cleared state next cycle
	property p_directClear;
		clearIn && !presetIn && !dcBoth_r |=> !q_r && qn_r;
	endproperty
	a_directClear: assert property (p_directClear)
		else $error("direct clear did not override clocked path");

	// both direct inputs: both outputs false
	property p_bothLow;
		s_bothDc |=> !q_r && !qn_r;
	endproperty
	a_bothLow: assert property (p_bothLow)
		else $error("outputs not both false under double direct input");

	// survivor held for the hold time: state taken, not earlier
	property p_releaseLate;
		s_bothDc ##1 s_presetOnly [*8] |=> q_r && !qn_r;
	endproperty
	a_releaseLate: assert property (p_releaseLate)
		else $error("preset survivor not taken after hold time");

	property p_releaseEarly;
		s_bothDc ##1 s_presetOnly [*7] |=> !q_r && !qn_r;
	endproperty
	a_releaseEarly: assert property (p_releaseEarly)
		else $error("preset survivor taken before hold time");

endmodule

// ### tb/sep_gate_model.sv
// gate logic model that feeds the clocked flip-flop
module sep_gate_model
(
	// system clock and reset
	input wire logic clock,
	input wire logic srst,
	// one-cycle transfer request and its levels
	input wire logic go,
	input wire logic s,
	input wire logic r,
	// flip-flop drive
	output logic phaseClk,
	output logic setIn,
	output logic resetIn
);
	timeunit 1ns;
	timeprecision 1ps;

	// settle before fall
	// levels move while the element clock is low or rising, and while it is
	// high only when go stays true, so with a one-cycle go the fall sees them steady
	always_ff @(posedge clock)
	begin
		phaseClk <= go & ~srst;
		if (srst)
		begin
			setIn <= 1'h0;
			resetIn <= 1'h0;
		end
		else if (go || !phaseClk)
		begin
			setIn <= s;
			resetIn <= r;
		end
	end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the storage element pair
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, srst, go, s, r, presetIn, clearIn, highIn, wipeIn;
	logic phaseClk, setIn, resetIn, stateOut, stateOutN, outBit, prev;
	int error_cnt = 0;
	int compares = 0;
	// rows: set-side input, reset-side input, expected state
	logic [2:0] rows [6] = '{3'h5, 3'h1, 3'h2, 3'h0, 3'h7, 3'h2};

	sep_gate_model i_sep_gate_model (.clock(clock), .srst(srst), .go(go),
		.s(s), .r(r), .phaseClk(phaseClk), .setIn(setIn),
		.resetIn(resetIn));
	sep_storage_pair i_sep_storage_pair (.clock(clock), .srst(srst),
		.phaseClk(phaseClk), .setIn(setIn), .resetIn(resetIn),
		.presetIn(presetIn), .clearIn(clearIn), .stateOut(stateOut),
		.stateOutN(stateOutN), .highIn(highIn), .wipeIn(wipeIn),
		.outBit(outBit));

	// compare and count
	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic end_of_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// free-running system clock
	initial
	begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	// watchdog: the run needs under a hundred cycles, this allows four hundred
	initial
	begin
		#2000;
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		srst = 1'h1;
		go = 1'h0;
		s = 1'h0;
		r = 1'h0;
		presetIn = 1'h0;
		clearIn = 1'h0;
		highIn = 1'h0;
		wipeIn = 1'h0;
		prev = 1'h0;
		tick(8);
		srst <= 1'h0;
		tick(1);
		#1 check({stateOut, stateOutN}, 2'h1);
		check({1'h0, outBit}, 2'h0);
		// same levels drive the latch and one flip-flop transfer
		foreach (rows[i])
		begin
			tick(1);
			go <= 1'h1;
			s <= rows[i][2];
			r <= rows[i][1];
			highIn <= rows[i][2];
			wipeIn <= rows[i][1];
			tick(1);
			go <= 1'h0;
			tick(1);
			#1 check({1'h0, outBit}, {1'h0, rows[i][0]});
			check({stateOut, stateOutN}, {prev, ~prev});
			tick(1);
			#1 check({stateOut, stateOutN}, {rows[i][0], ~rows[i][0]});
			prev = rows[i][0];
		end
		// levels moved while the element clock is low wait for it
		tick(1);
		s <= 1'h1;
		r <= 1'h0;
		tick(3);
		#1 check({stateOut, stateOutN}, 2'h1);
		tick(1);
		go <= 1'h1;
		tick(1);
		go <= 1'h0;
		tick(2);
		#1 check({stateOut, stateOutN}, 2'h2);
		// direct clear, preset, then both with a surviving preset
		tick(1);
		clearIn <= 1'h1;
		tick(1);
		clearIn <= 1'h0;
		presetIn <= 1'h1;
		#1 check({stateOut, stateOutN}, 2'h1);
		tick(1);
		clearIn <= 1'h1;
		#1 check({stateOut, stateOutN}, 2'h2);
		tick(1);
		clearIn <= 1'h0;
		#1 check({stateOut, stateOutN}, 2'h0);
		tick(7);
		#1 check({stateOut, stateOutN}, 2'h0);
		tick(1);
		#1 check({stateOut, stateOutN}, 2'h2);
		// both dropped together: indeterminate, settles cleared
		tick(1);
		clearIn <= 1'h1;
		tick(1);
		presetIn <= 1'h0;
		clearIn <= 1'h0;
		#1 check({stateOut, stateOutN}, 2'h0);
		tick(1);
		#1 check({stateOut, stateOutN}, 2'h1);
		// both, then a surviving clear held through the hold time
		tick(1);
		presetIn <= 1'h1;
		clearIn <= 1'h1;
		tick(1);
		presetIn <= 1'h0;
		#1 check({stateOut, stateOutN}, 2'h0);
		tick(7);
		#1 check({stateOut, stateOutN}, 2'h0);
		tick(1);
		#1 check({stateOut, stateOutN}, 2'h1);
		// second reset in mid-run, from a set flip-flop and a set latch
		tick(1);
		clearIn <= 1'h0;
		presetIn <= 1'h1;
		highIn <= 1'h1;
		wipeIn <= 1'h0;
		tick(1);
		presetIn <= 1'h0;
		highIn <= 1'h0;
		#1 check({stateOut, stateOutN}, 2'h2);
		check({1'h0, outBit}, 2'h1);
		tick(1);
		srst <= 1'h1;
		tick(1);
		srst <= 1'h0;
		#1 check({stateOut, stateOutN}, 2'h1);
		check({1'h0, outBit}, 2'h0);
		tick(1);
		#1 check({stateOut, stateOutN}, 2'h1);
		check({1'h0, outBit}, 2'h0);
		end_of_test();
	end
endmodule
